/* File: hdl/mcrc_pkg.sv */
// Package of constants for the MAC clock and reset control block
package mcrc_pkg;
    // Documented clock rates, MAC clocks in kHz and recovered clocks in Hz, kept as printed
    localparam int TXMAC_FREQ_KHZ = 390625;
    localparam int RXMAC_FREQ_KHZ = 390625;
    localparam longint RECOVER_FREQ_HZ_TEN = 64'd322265625;
    localparam longint RECOVER_FREQ_HZ_FOUR = 64'd402832030;
    // Lane counts per variant
    localparam int LANES_TEN = 10;
    localparam int LANES_FOUR = 4;
    // Core clock period and least hold time of the full-core reset
    localparam int CORE_CLK_PERIOD_NS = 25;
    localparam int STATUS_CLK_MIN_PERIOD_NS = 8;
    localparam int RESET_HOLD_STATUS_CYCLES = 10;
    localparam int RESET_HOLD_NS = RESET_HOLD_STATUS_CYCLES * STATUS_CLK_MIN_PERIOD_NS;
    localparam int RESET_HOLD_CYCLES_RAW =
        (RESET_HOLD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_CYCLES_RAW < 1) ? 1 : RESET_HOLD_CYCLES_RAW;
    // Depth of each reset release synchroniser
    localparam int SYNC_STAGES = 2;
    // Value of every flop after reset
    localparam logic RESET_ACTIVE = 1'b0;
endpackage

/* File: hdl/mcrc_rst_sync.sv */
// Reset release synchroniser: asserts at once, releases on the clock
`timescale 1ns/1ps
module mcrc_rst_sync #(
    parameter int STAGES = mcrc_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Synchronised reset, active low
    output logic srst_n
);
    logic [STAGES-1:0] chain_q;
    logic [STAGES-1:0] chain_d;

    // Shift ones in after release; the first stage feeds only the second
    always_comb begin
        chain_d = {chain_q[STAGES-2:0], 1'b1};
    end

    // Constant on assertion, so release never glitches a domain mid-cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= chain_d;
        end
    end

    assign srst_n = chain_q[STAGES-1];
endmodule

/* File: hdl/mcrc_top.sv */
// Clock and reset control for a 100G MAC core
// Contract
// - Provide 390.625 MHz transmit MAC clock output
// - External PLL option drives transmit clock directly
// - Provide 390.625 MHz receive MAC clock output
// - Receive clock derives from recovered serial clock
// - Recovered clock output only with option enabled
// - Recovered clock 322.265625 or 402.83203 MHz
// - One asynchronous reset resets whole core
// - Status reset clears only status interface
// - Reconfiguration reset clears only reconfiguration port
// - Four or ten serial links by variant
`timescale 1ns/1ps
module mcrc_top #(
    parameter int LANES = mcrc_pkg::LANES_TEN,
    parameter bit EXT_TXMAC_PLL = 1'b0,
    parameter bit SYNC_ETH_OPTION = 1'b0,
    parameter bit HAS_RECONFIG = 1'b1
) (
    // Core clock and full-core reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Clock sources, taken as sampled levels of each source
    input wire logic int_txmac_clk,
    input wire logic ext_txmac_clk,
    input wire logic [LANES-1:0] rx_lane_recovered_clk,
    input wire logic rx_pcs_ready,
    // Synchronous interface resets, active high
    input wire logic status_reset,
    input wire logic reconfig_reset,
    // Clock outputs
    output logic txmac_clk,
    output logic rxmac_clk,
    output logic rx_recover_clk,
    output logic rx_clk_valid,
    // Reset outputs, active low, and the hold flag, active high
    output logic core_rst_n,
    output logic status_rst_n,
    output logic reconfig_rst_n,
    output logic hold_ok
);
    logic core_srst_n;
    logic txmac_clk_q, txmac_clk_d;
    logic rxmac_clk_q, rxmac_clk_d;
    logic recover_q, recover_d;
    logic valid_q, valid_d;
    logic core_rst_q, core_rst_d;
    logic status_rst_q, status_rst_d;
    logic reconfig_rst_q, reconfig_rst_d;
    logic [7:0] hold_cnt_q, hold_cnt_d;
    logic hold_ok_q, hold_ok_d;

    // Release of the asynchronous reset, one synchroniser on the core clock shared by all three reset outputs
    mcrc_rst_sync #(.STAGES(mcrc_pkg::SYNC_STAGES)) u_core_sync (
        .clk(core_clk),
        .arst_n(reset_n),
        .srst_n(core_srst_n)
    );

    // Clock selection; the link count only sizes the recovered bus
    always_comb begin
        txmac_clk_d = EXT_TXMAC_PLL ? ext_txmac_clk : int_txmac_clk;
        rxmac_clk_d = rx_lane_recovered_clk[0];
        recover_d = SYNC_ETH_OPTION ? rx_lane_recovered_clk[0] : 1'b0;
        valid_d = rx_pcs_ready;
    end

    // Clock outputs from flops; absent recovered clock stays low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txmac_clk_q <= mcrc_pkg::RESET_ACTIVE;
            rxmac_clk_q <= mcrc_pkg::RESET_ACTIVE;
            recover_q <= mcrc_pkg::RESET_ACTIVE;
            valid_q <= mcrc_pkg::RESET_ACTIVE;
        end else begin
            txmac_clk_q <= txmac_clk_d;
            rxmac_clk_q <= rxmac_clk_d;
            recover_q <= recover_d;
            valid_q <= valid_d;
        end
    end

    // Interface resets: full reset covers all, sync resets only their own
    always_comb begin
        core_rst_d = core_srst_n;
        status_rst_d = core_srst_n && !status_reset;
        reconfig_rst_d = core_srst_n && !(HAS_RECONFIG && reconfig_reset);
    end

    // Hold counter counts core cycles after release and raises the flag once it reaches RESET_HOLD_CYCLES
    always_comb begin
        hold_cnt_d = hold_cnt_q;
        hold_ok_d = hold_ok_q;
        if (hold_cnt_q < 8'(mcrc_pkg::RESET_HOLD_CYCLES)) begin
            hold_cnt_d = hold_cnt_q + 8'h01;
        end else begin
            hold_ok_d = 1'b1;
        end
    end

    // Reset outputs are asserted at once under the asynchronous reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_rst_q <= mcrc_pkg::RESET_ACTIVE;
            status_rst_q <= mcrc_pkg::RESET_ACTIVE;
            reconfig_rst_q <= mcrc_pkg::RESET_ACTIVE;
        end else begin
            core_rst_q <= core_rst_d;
            status_rst_q <= status_rst_d;
            reconfig_rst_q <= reconfig_rst_d;
        end
    end

    // Hold counter restarts on every assertion and saturates, so it never wraps back low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_cnt_q <= 8'h00;
            hold_ok_q <= mcrc_pkg::RESET_ACTIVE;
        end else begin
            hold_cnt_q <= hold_cnt_d;
            hold_ok_q <= hold_ok_d;
        end
    end

    assign txmac_clk = txmac_clk_q;
    assign rxmac_clk = rxmac_clk_q;
    assign rx_recover_clk = recover_q;
    assign rx_clk_valid = valid_q;
    assign core_rst_n = core_rst_q;
    assign status_rst_n = status_rst_q;
    assign reconfig_rst_n = reconfig_rst_q;
    assign hold_ok = hold_ok_q;

    // Checks
    // Clock copies lag one edge; the first edge after release is skipped, as the
    // flops still show their reset level there and a live source would not match
    AST_TX_SEL: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) && EXT_TXMAC_PLL |-> txmac_clk == $past(ext_txmac_clk))
        else $error("tx mac clock not from external input");
    AST_TX_INT: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) && !EXT_TXMAC_PLL |-> txmac_clk == $past(int_txmac_clk))
        else $error("tx mac clock not from internal source");
    AST_RX_SRC: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) |-> rxmac_clk == $past(rx_lane_recovered_clk[0]))
        else $error("rx mac clock not from recovered clock");

    // Recovered clock output: absent without the option, lane 0 copy with it
    AST_RECOVER_ABSENT: assert property (@(posedge core_clk) disable iff (!reset_n)
        !SYNC_ETH_OPTION |-> !rx_recover_clk)
        else $error("recovered clock present without option");
    AST_RECOVER_SRC: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) && SYNC_ETH_OPTION |-> rx_recover_clk == $past(rx_lane_recovered_clk[0]))
        else $error("recovered clock not from lane 0");

    // Validity flag tracks readiness one edge late in both directions
    AST_VALID: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(rx_pcs_ready) |=> rx_clk_valid)
        else $error("rx clock valid late");
    AST_VALID_FOLLOW: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) |-> rx_clk_valid == $past(rx_pcs_ready))
        else $error("rx clock valid not following readiness");

    // Release steps: two synchroniser stages, then the output flop
    sequence s_released;
        !core_rst_n ##1 core_rst_n;
    endsequence
    sequence s_reset_lift;
        $rose(reset_n);
    endsequence
    sequence s_core_up;
        !core_rst_n [*3] ##1 core_rst_n;
    endsequence
    sequence s_hold_up;
        !hold_ok [*5] ##1 hold_ok;
    endsequence
    AST_CORE_REL: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_released |-> core_srst_n)
        else $error("core reset release not synchronised");
    AST_CORE_SEQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_reset_lift |-> s_core_up)
        else $error("core reset released on the wrong edge");
    AST_HOLD_SEQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_reset_lift |-> s_hold_up)
        else $error("hold flag raised on the wrong edge");

    // Assertion must not wait for a clock; no disable here, as reset is the subject
    AST_ASYNC_CLEAR: assert property (@(posedge core_clk)
        ($past(reset_n) && !reset_n) |-> (!core_rst_n && !status_rst_n && !reconfig_rst_n && !hold_ok))
        else $error("full reset did not clear outputs at once");

    // Interface resets touch only their own interface
    AST_STATUS: assert property (@(posedge core_clk) disable iff (!reset_n)
        (status_reset && core_rst_n) |=> (!status_rst_n && core_rst_n))
        else $error("status reset wrong scope");
    AST_STATUS_REL: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!status_reset && core_rst_n) |=> status_rst_n)
        else $error("status interface held in reset");
    AST_RECONFIG: assert property (@(posedge core_clk) disable iff (!reset_n)
        (HAS_RECONFIG && reconfig_reset && !status_reset && core_rst_n)
            |=> (!reconfig_rst_n && status_rst_n))
        else $error("reconfig reset wrong scope");
    AST_RECONFIG_ABSENT: assert property (@(posedge core_clk) disable iff (!reset_n)
        !HAS_RECONFIG |-> reconfig_rst_n == core_rst_n)
        else $error("reconfig reset acts without the port");
    AST_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
        hold_ok |-> hold_cnt_q == 8'(mcrc_pkg::RESET_HOLD_CYCLES))
        else $error("hold count wrong");
    AST_CORE_ALL: assert property (@(posedge core_clk) disable iff (!reset_n)
        !core_rst_n |-> (!status_rst_n && !reconfig_rst_n))
        else $error("full reset not covering interfaces");
endmodule

/* File: test/mcrc_user_model.sv */
// User-side model: transmit clock sources, recovered lane clocks, receive readiness
`timescale 1ns/1ps
module mcrc_user_model #(
    parameter int LANES = 10
) (
    // Core clock
    input wire logic core_clk,
    // Recovered clock out of the block, filtered here
    input wire logic rx_recover_clk,
    // Clock source levels
    output logic int_txmac_clk,
    output logic ext_txmac_clk,
    output logic [LANES-1:0] rx_lane_recovered_clk,
    // Receive status
    output logic rx_pcs_ready
);
    logic ref_level = 1'h0;
    logic [1:0] filt_q = 2'h0;

    // Known levels before the first edge
    initial begin
        int_txmac_clk = 1'h0;
        ext_txmac_clk = 1'h0;
        rx_lane_recovered_clk = '0;
        rx_pcs_ready = 1'h0;
    end

    // Reference is the recovered clock after a two-sample glitch filter kept on this side;
    // both sources follow it, but in opposite phase so the selection shows
    always @(negedge core_clk) begin
        filt_q <= {filt_q[0], rx_recover_clk};
        if (filt_q[1] == filt_q[0]) begin
            ref_level <= filt_q[0];
        end
        int_txmac_clk <= ~ref_level;
        ext_txmac_clk <= ref_level;
        // Recovered levels change with the incoming data
        rx_lane_recovered_clk <= LANES'($urandom);
        rx_pcs_ready <= ($urandom_range(3) != 0);
    end
endmodule

/* File: test/test_mcrc_top.sv */
// Self-checking bench for the MAC clock and reset control block
`timescale 1ns/1ps
module test_mcrc_top;
    logic core_clk = 1'h0;
    logic reset_n = 1'h0;
    logic status_reset = 1'h0;
    logic reconfig_reset = 1'h0;
    logic run_cmp = 1'h0;
    logic rel_q[$] = '{1'h0, 1'h0, 1'h1};
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    wire logic int_src, ext_src, ready;
    wire logic [9:0] lanes;
    wire logic [1:0] txmac, rxmac, recov, valid, core_rn, stat_rn, reconf_rn, hold;

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    mcrc_user_model i_mcrc_user_model (.core_clk(core_clk), .rx_recover_clk(recov[1]),
        .int_txmac_clk(int_src),
        .ext_txmac_clk(ext_src), .rx_lane_recovered_clk(lanes), .rx_pcs_ready(ready));
    // Ten lanes, internal transmit clock, reconfiguration port present
    mcrc_top i_mcrc_top (.core_clk(core_clk), .reset_n(reset_n), .int_txmac_clk(int_src),
        .ext_txmac_clk(ext_src), .rx_lane_recovered_clk(lanes), .rx_pcs_ready(ready),
        .status_reset(status_reset), .reconfig_reset(reconfig_reset), .txmac_clk(txmac[0]),
        .rxmac_clk(rxmac[0]), .rx_recover_clk(recov[0]), .rx_clk_valid(valid[0]),
        .core_rst_n(core_rn[0]), .status_rst_n(stat_rn[0]), .reconfig_rst_n(reconf_rn[0]),
        .hold_ok(hold[0]));
    // Four lanes, external transmit clock, recovered clock out, no reconfiguration port
    mcrc_top #(.LANES(4), .EXT_TXMAC_PLL(1'h1), .SYNC_ETH_OPTION(1'h1), .HAS_RECONFIG(1'h0))
    i_mcrc_top_ext (.core_clk(core_clk), .reset_n(reset_n), .int_txmac_clk(int_src),
        .ext_txmac_clk(ext_src), .rx_lane_recovered_clk(lanes[3:0]), .rx_pcs_ready(ready),
        .status_reset(status_reset), .reconfig_reset(reconfig_reset), .txmac_clk(txmac[1]),
        .rxmac_clk(rxmac[1]), .rx_recover_clk(recov[1]), .rx_clk_valid(valid[1]),
        .core_rst_n(core_rn[1]), .status_rst_n(stat_rn[1]), .reconfig_rst_n(reconf_rn[1]),
        .hold_ok(hold[1]));

    task automatic check(input string what, input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Reference model: each output equals what its source held at the last rising edge
    always @(negedge core_clk) begin
        if (run_cmp) begin
            check("txmac int", txmac[0], int_src);
            check("txmac ext", txmac[1], ext_src);
            check("rxmac ten", rxmac[0], lanes[0]);
            check("rxmac four", rxmac[1], lanes[0]);
            check("recover off", recov[0], 1'h0);
            check("recover on", recov[1], lanes[0]);
            check("rx valid", valid[0], ready);
            check("rx valid four", valid[1], ready);
            check("core rst", core_rn[0], 1'h1);
            check("core rst four", core_rn[1], 1'h1);
            check("status rst", stat_rn[1], ~status_reset);
            check("status rst ten", stat_rn[0], ~status_reset);
            check("reconfig rst", reconf_rn[0], ~reconfig_reset);
            check("reconfig absent", reconf_rn[1], 1'h1);
            check("hold ok", hold[0], 1'h1);
        end
    end

    // Full-core reset: immediate assertion, release three edges later; at the start the
    // reset already stands from time zero
    task automatic do_reset();
        int k;
        if (run_cmp) begin
            @(negedge core_clk);
            run_cmp <= 1'h0;
            @(negedge core_clk);
            status_reset <= 1'h0;
            reconfig_reset <= 1'h0;
            reset_n <= 1'h0;
            #1;
            for (k = 0; k < 2; k++) begin
                check("core rst async", core_rn[k], 1'h0);
                check("status rst async", stat_rn[k], 1'h0);
                check("hold async", hold[k], 1'h0);
            end
        end
        // Four core cycles exceed ten cycles of the fastest status clock; the model's
        // reference runs throughout, so it is stable well before release
        repeat (4) @(negedge core_clk);
        reset_n <= 1'h1;
        for (k = 0; k < 3; k++) begin
            @(negedge core_clk);
            check("core rst release", core_rn[0], rel_q[k]);
            check("reconfig release", reconf_rn[1], rel_q[k]);
        end
        repeat (10) @(negedge core_clk);
        check("hold after release", hold[1], 1'h1);
        run_cmp <= 1'h1;
    endtask

    // Cuts a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 1000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        void'($urandom(46974));
        do_reset();
        $display("test reset release done");
        // Interface resets at random; the core clock stands in for the status clock
        repeat (300) begin
            @(negedge core_clk);
            status_reset <= ($urandom_range(3) == 0);
            reconfig_reset <= ($urandom_range(3) == 0);
        end
        $display("test random traffic done");
        do_reset();
        repeat (100) @(negedge core_clk);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
